// >>> hdl/program_flow_sequencer.sv
// program flow sequencer: subroutine calls, scheduled interrupt timer, step control
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`default_nettype none
module program_flow_sequencer #(
  parameter int TICK_CYCLES = flow_seq_pkg::TICK_CYCLES,
  parameter int NEST_DEPTH  = flow_seq_pkg::NEST_MAX
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [15:0] currentPc,
  input  wire logic [31:0] extIrq,
  input  wire logic        scanEnd,
  input  wire logic        powerFail,
  output var flow_seq_pkg::jump_s jumpOut,
  output logic             instrErrorFlag,
  output logic             stepStartFlag,
  output logic             stepExec,
  output logic [15:0]      stepClearMask
);
  // the return stack holds sixteen frames; a shorter tick count cannot wrap
  if (TICK_CYCLES < 2 || NEST_DEPTH < 1 || NEST_DEPTH > 16) begin : g_param_check
    $error("program_flow_sequencer: unsupported parameter");
  end

  function automatic logic bcdValid(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[i*4 +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : bcdValid

  // digit-wise borrow; zero wraps to 9999, which the timer reaches with an interval of 0001
  function automatic logic [15:0] bcdDec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (v[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcdDec

  function automatic logic [6:0] bcdToSub(input logic [7:0] v);
    return 7'({3'h0, v[7:4]} * 7'h0a + {3'h0, v[3:0]});
  endfunction : bcdToSub

  // bus slave: hreadyout follows clkEn, read data registered in the address phase
  logic        wrPendReg;
  logic [7:0]  wrAddrReg;
  logic [31:0] rdataReg;
  logic        addrPhase;
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = clkEn;
  assign hresp     = 1'b0;
  assign hrdata    = rdataReg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wrPendReg <= 1'b0;
      wrAddrReg <= 8'h00;
    end else if (clkEn) begin
      wrPendReg <= addrPhase && hwrite;
      wrAddrReg <= haddr[7:0];
    end
  end

  logic wrCall, wrRet, wrScan, wrEntry, wrIntData, wrIntCmd, wrStart, wrDef, wrCtl, wrStatus;
  assign wrStatus  = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_STATUS;
  assign wrCall    = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_CALL;
  assign wrRet     = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_RETURN;
  assign wrScan    = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_SCAN_END;
  assign wrEntry   = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_ENTRY;
  assign wrIntData = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_INT_DATA;
  assign wrIntCmd  = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_INT_CMD;
  assign wrStart   = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_STEP_START;
  assign wrDef     = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_STEP_DEF;
  assign wrCtl     = wrPendReg && wrAddrReg == flow_seq_pkg::ADDR_STEP_CTL;

  // subroutine table and return stack
  logic [15:0]          entryMem [flow_seq_pkg::SUB_COUNT];
  logic [99:0]          definedReg;
  flow_seq_pkg::frame_s stackMem [16];
  logic [4:0]           depthReg;
  logic [6:0]           curSubReg;
  logic                 errReg;
  logic [31:0]          extPendReg;
  logic                 schedPendReg;
  logic [15:0]          stepCtlReg;

  logic [6:0] callSub;
  logic       callReq, callErr, callGo, retGo, retErr, depthFull;
  assign callSub   = bcdToSub(hwdata[7:0]);
  assign depthFull = depthReg == 5'(NEST_DEPTH);
  assign callReq   = wrCall && hwdata[flow_seq_pkg::CALL_COND_BIT] && !errReg;
  assign callErr   = callReq && (!bcdValid({8'h00, hwdata[7:0]})
                     || !definedReg[callSub] || callSub == curSubReg || depthFull);
  assign callGo    = callReq && !callErr;
  assign retGo     = wrRet && depthReg != 5'h00;
  assign retErr    = wrRet && depthReg == 5'h00;

  // interrupt entry waits for a free cycle; lower external number wins, then the schedule
  logic       irqGo;
  logic [6:0] irqSub;
  always_comb begin
    irqGo  = 1'b0;
    irqSub = flow_seq_pkg::SUB_SCHED;
    if (!wrCall && !wrRet && !depthFull) begin
      for (int i = flow_seq_pkg::EXT_IRQ_COUNT - 1; i >= 0; i--) begin
        if (extPendReg[i] && definedReg[i] && curSubReg != 7'(i)) begin
          irqGo  = 1'b1;
          irqSub = 7'(i);
        end
      end
      if (!irqGo && schedPendReg && definedReg[flow_seq_pkg::SUB_SCHED]
          && curSubReg != flow_seq_pkg::SUB_SCHED) begin
        irqGo = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      depthReg  <= 5'h00;
      curSubReg <= flow_seq_pkg::SUB_MAIN;
    end else if (clkEn) begin
      if (callGo) begin
        stackMem[depthReg[3:0]] <= '{pc: currentPc + 16'h0001, sub: curSubReg};
        depthReg  <= depthReg + 5'h01;
        curSubReg <= callSub;
      end else if (retGo) begin
        depthReg  <= depthReg - 5'h01;
        curSubReg <= stackMem[4'(depthReg - 5'h01)].sub;
      end else if (irqGo) begin
        stackMem[depthReg[3:0]] <= '{pc: currentPc, sub: curSubReg};
        depthReg  <= depthReg + 5'h01;
        curSubReg <= irqSub;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      jumpOut <= '{valid: 1'b0, addr: flow_seq_pkg::PC_RESTART};
    end else if (clkEn) begin
      jumpOut.valid <= callGo || retGo || irqGo || wrScan;
      if (callGo) begin
        jumpOut.addr <= entryMem[callSub];
      end else if (retGo) begin
        jumpOut.addr <= stackMem[4'(depthReg - 5'h01)].pc;
      end else if (irqGo) begin
        jumpOut.addr <= entryMem[irqSub];
      end else if (wrScan) begin
        jumpOut.addr <= flow_seq_pkg::PC_RESTART;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      definedReg <= '0;
    end else if (clkEn && wrEntry && bcdValid({8'h00, hwdata[31:24]})) begin
      definedReg[bcdToSub(hwdata[31:24])] <= hwdata[flow_seq_pkg::ENTRY_DEF_BIT];
      entryMem[bcdToSub(hwdata[31:24])]   <= hwdata[15:0];
    end
  end

  // external requests are sticky; a new edge in the entry cycle is kept
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      extPendReg <= '0;
    end else if (clkEn) begin
      for (int i = 0; i < flow_seq_pkg::EXT_IRQ_COUNT; i++) begin
        if (extIrq[i]) begin
          extPendReg[i] <= 1'b1;
        end else if (irqGo && irqSub == 7'(i)) begin
          extPendReg[i] <= 1'b0;
        end
      end
    end
  end

  // scheduled timer
  localparam int TICK_W = $clog2(TICK_CYCLES);
  logic [TICK_W-1:0]          tickCntReg;
  logic                       tick;
  flow_seq_pkg::timer_state_e tmStateReg;
  logic [15:0]                intDataReg, intervalPendReg, intervalActReg, countReg, intReadReg;
  logic                       intervalSetReg;
  logic [11:0]                intCode, intDesig;
  logic                       intErr, intOk;
  assign tick     = tickCntReg == TICK_W'(TICK_CYCLES - 1);
  assign intCode  = hwdata[11:0];
  assign intDesig = hwdata[flow_seq_pkg::INT_DESIG_LSB +: 12];
  assign intErr   = wrIntCmd && (intDesig != flow_seq_pkg::INT_DESIGNATOR
                    || intCode > flow_seq_pkg::CC_READ || !bcdValid(intDataReg));
  assign intOk    = wrIntCmd && !intErr;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickCntReg <= '0;
    end else if (clkEn) begin
      tickCntReg <= tick ? '0 : tickCntReg + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      intDataReg <= flow_seq_pkg::BCD_ZERO;
    end else if (clkEn && wrIntData) begin
      intDataReg <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tmStateReg      <= flow_seq_pkg::TM_IDLE;
      intervalPendReg <= flow_seq_pkg::BCD_ZERO;
      intervalActReg  <= flow_seq_pkg::BCD_ZERO;
      countReg        <= flow_seq_pkg::BCD_ZERO;
      intervalSetReg  <= 1'b0;
      intReadReg      <= flow_seq_pkg::BCD_ZERO;
    end else if (clkEn) begin
      if (intOk && intCode == flow_seq_pkg::CC_INTERVAL) begin
        intervalPendReg <= intDataReg;
        intervalSetReg  <= intDataReg != flow_seq_pkg::BCD_ZERO;
        if (tmStateReg != flow_seq_pkg::TM_RUN) begin
          intervalActReg <= intDataReg;
        end
        if (intDataReg == flow_seq_pkg::BCD_ZERO) begin
          tmStateReg <= flow_seq_pkg::TM_IDLE;
        end
      end else if (intOk && intCode == flow_seq_pkg::CC_FIRST) begin
        countReg   <= intDataReg;
        tmStateReg <= (intDataReg == flow_seq_pkg::BCD_ZERO) ? flow_seq_pkg::TM_IDLE
                      : flow_seq_pkg::TM_RUN;
      end else if (intOk && intCode == flow_seq_pkg::CC_READ) begin
        intReadReg <= intervalActReg;
      end else if (tick) begin
        unique case (tmStateReg)
          flow_seq_pkg::TM_IDLE: begin
          end
          flow_seq_pkg::TM_RUN: begin
            if (countReg != flow_seq_pkg::BCD_ONE) begin
              countReg <= bcdDec(countReg);
            end else if (!intervalSetReg) begin
              tmStateReg <= flow_seq_pkg::TM_IDLE;
            end else begin
              countReg       <= intervalPendReg;
              intervalActReg <= intervalPendReg;
              tmStateReg     <= flow_seq_pkg::TM_HOLD;
            end
          end
          flow_seq_pkg::TM_HOLD: begin
            tmStateReg <= flow_seq_pkg::TM_RUN;
            countReg   <= bcdDec(countReg);
          end
        endcase
      end
    end
  end

  logic schedFire;
  assign schedFire = clkEn && tick && !wrIntCmd && tmStateReg == flow_seq_pkg::TM_RUN
                     && countReg == flow_seq_pkg::BCD_ONE && intervalSetReg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      schedPendReg <= 1'b0;
    end else if (clkEn) begin
      if (schedFire) begin
        schedPendReg <= 1'b1;
      end else if (irqGo && irqSub == flow_seq_pkg::SUB_SCHED) begin
        schedPendReg <= 1'b0;
      end
    end
  end

  // error flag: a new error wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      errReg <= 1'b0;
    end else if (clkEn) begin
      if (callErr || retErr || intErr) begin
        errReg <= 1'b1;
      end else if (wrStatus && hwdata[flow_seq_pkg::STATUS_ERR_BIT]) begin
        errReg <= 1'b0;
      end
    end
  end
  assign instrErrorFlag = errReg;

  // step sequencing
  logic       stepModeReg, curStepValidReg, retainReg, stepExecReg, stepFlagReg;
  logic [3:0] curStepReg;
  logic [15:0] clearMaskReg;
  logic [3:0]  stepIdx;
  assign stepIdx = hwdata[3:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stepCtlReg      <= '0;
      retainReg       <= 1'b0;
      stepModeReg     <= 1'b0;
      curStepValidReg <= 1'b0;
      curStepReg      <= 4'h0;
      stepExecReg     <= 1'b0;
      clearMaskReg    <= '0;
    end else if (clkEn) begin
      clearMaskReg <= '0;
      if (powerFail && !retainReg) begin
        stepCtlReg <= '0;
      end else if (wrStart && hwdata[flow_seq_pkg::STEP_FLAG_BIT]) begin
        stepCtlReg[stepIdx] <= 1'b1;
        stepModeReg         <= 1'b1;
        if (stepExecReg && curStepReg != stepIdx) begin
          stepCtlReg[curStepReg]   <= 1'b0;
          clearMaskReg[curStepReg] <= 1'b1;
          stepExecReg              <= 1'b0;
        end
      end else if (wrDef && hwdata[flow_seq_pkg::STEP_FLAG_BIT]) begin
        curStepReg      <= stepIdx;
        curStepValidReg <= 1'b1;
        stepExecReg     <= stepModeReg && stepCtlReg[stepIdx];
      end else if (wrDef) begin
        stepModeReg     <= 1'b0;
        curStepValidReg <= 1'b0;
        stepExecReg     <= 1'b0;
      end else if (wrCtl) begin
        stepCtlReg   <= hwdata[15:0];
        retainReg    <= hwdata[flow_seq_pkg::STEP_RETAIN_BIT];
        clearMaskReg <= stepCtlReg & ~hwdata[15:0];
        if (stepExecReg && !hwdata[curStepReg]) begin
          stepExecReg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stepFlagReg <= 1'b0;
    end else if (clkEn) begin
      if (wrDef) begin
        stepFlagReg <= 1'b1;
      end else if (scanEnd) begin
        stepFlagReg <= 1'b0;
      end
    end
  end
  assign stepStartFlag = stepFlagReg;
  assign stepExec      = stepExecReg;
  assign stepClearMask = clearMaskReg;

  // read mux
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdataReg <= '0;
    end else if (clkEn && addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        flow_seq_pkg::ADDR_STATUS:   rdataReg <= {9'h000, curSubReg, 3'h0, depthReg, 4'h0,
                                      stepFlagReg, tmStateReg == flow_seq_pkg::TM_RUN,
                                      stepModeReg, errReg};
        flow_seq_pkg::ADDR_INT_DATA: rdataReg <= {16'h0000, intDataReg};
        flow_seq_pkg::ADDR_INT_CMD:  rdataReg <= {16'h0000, intReadReg};
        flow_seq_pkg::ADDR_STEP_CTL: rdataReg <= {15'h0000, retainReg, stepCtlReg};
        flow_seq_pkg::ADDR_TIMER:    rdataReg <= {countReg, intervalActReg};
        default:                     rdataReg <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  call_blocked_a: assert property (clkEn && wrCall && errReg |=> !jumpOut.valid)
    else $error("call taken while error flag on");
  self_call_a: assert property (clkEn && callReq && callSub == curSubReg |=> errReg)
    else $error("self call did not raise error");
  nest_limit_a: assert property (depthReg <= 5'(NEST_DEPTH))
    else $error("nesting deeper than limit");
  call_push_a: assert property (clkEn && callGo |=> depthReg == $past(depthReg) + 5'h01
    && jumpOut.valid)
    else $error("call did not push a frame");
  scan_restart_a: assert property (clkEn && wrScan && !callGo && !retGo && !irqGo
    |=> jumpOut.valid && jumpOut.addr == flow_seq_pkg::PC_RESTART)
    else $error("scan end did not restart at zero");
  int_error_a: assert property (clkEn && wrIntCmd && intDesig != flow_seq_pkg::INT_DESIGNATOR
    |=> errReg)
    else $error("bad designator not flagged");
  cancel_stops_a: assert property (clkEn && intOk && intCode == flow_seq_pkg::CC_INTERVAL
    && intDataReg == flow_seq_pkg::BCD_ZERO |=> tmStateReg == flow_seq_pkg::TM_IDLE)
    else $error("zero interval did not cancel");
  first_reload_a: assert property (clkEn && intOk && intCode == flow_seq_pkg::CC_FIRST
    |=> countReg == $past(intDataReg))
    else $error("first delay not reloaded");
  fire_needs_a: assert property (schedFire |-> intervalPendReg != flow_seq_pkg::BCD_ZERO)
    else $error("schedule fired without interval");
  fire_pend_a: assert property (schedFire |=> schedPendReg)
    else $error("scheduled request lost");
  step_skip_a: assert property (clkEn && wrDef && hwdata[flow_seq_pkg::STEP_FLAG_BIT]
    && !stepCtlReg[stepIdx] && !powerFail |=> !stepExecReg)
    else $error("unstarted step executed");
  step_flag_a: assert property (clkEn && wrDef |=> stepStartFlag)
    else $error("step start flag not raised");

  nested_call_c: cover property (callGo && depthReg == 5'h01);
  sched_entry_c: cover property (irqGo && irqSub == flow_seq_pkg::SUB_SCHED);
  step_complete_c: cover property (clearMaskReg != '0);
  nest_full_c: cover property (callErr && depthFull);
endmodule : program_flow_sequencer
`default_nettype wire

// >>> hdl/flow_seq_pkg.sv
// package: register map, field layout, timing and carrier types of the flow sequencer
`default_nettype none
package flow_seq_pkg;
  localparam logic [7:0] ADDR_STATUS     = 8'h00;
  localparam logic [7:0] ADDR_CALL       = 8'h04;
  localparam logic [7:0] ADDR_RETURN     = 8'h08;
  localparam logic [7:0] ADDR_SCAN_END   = 8'h0c;
  localparam logic [7:0] ADDR_ENTRY      = 8'h10;
  localparam logic [7:0] ADDR_INT_DATA   = 8'h14;
  localparam logic [7:0] ADDR_INT_CMD    = 8'h18;
  localparam logic [7:0] ADDR_STEP_START = 8'h1c;
  localparam logic [7:0] ADDR_STEP_DEF   = 8'h20;
  localparam logic [7:0] ADDR_STEP_CTL   = 8'h24;
  localparam logic [7:0] ADDR_TIMER      = 8'h28;

  localparam int STATUS_ERR_BIT   = 0;
  localparam int STATUS_STEP_BIT  = 1;
  localparam int STATUS_RUN_BIT   = 2;
  localparam int STATUS_FLAG_BIT  = 3;
  localparam int STATUS_DEPTH_LSB = 8;
  localparam int STATUS_SUB_LSB   = 16;
  localparam int CALL_COND_BIT    = 8;
  localparam int ENTRY_DEF_BIT    = 16;
  localparam int ENTRY_SUB_LSB    = 24;
  localparam int INT_DESIG_LSB    = 16;
  localparam int STEP_FLAG_BIT    = 4;
  localparam int STEP_RETAIN_BIT  = 16;

  localparam int NEST_MAX      = 16;
  localparam int SUB_COUNT     = 100;
  localparam int EXT_IRQ_COUNT = 32;
  localparam int STEP_BITS     = 16;
  localparam logic [6:0] SUB_SCHED = 7'h63;
  localparam logic [6:0] SUB_MAIN  = 7'h7f;

  localparam logic [11:0] INT_DESIGNATOR = 12'h004;
  localparam logic [11:0] CC_INTERVAL    = 12'h000;
  localparam logic [11:0] CC_FIRST       = 12'h001;
  localparam logic [11:0] CC_READ        = 12'h002;
  localparam logic [15:0] PC_RESTART     = 16'h0000;
  localparam logic [15:0] BCD_ZERO       = 16'h0000;
  localparam logic [15:0] BCD_ONE        = 16'h0001;

  localparam int CLK_PERIOD_NS  = 25;
  localparam int TICK_PERIOD_NS = 10000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    TM_IDLE = 3'b001,
    TM_RUN  = 3'b010,
    TM_HOLD = 3'b100
  } timer_state_e;

  typedef struct packed {
    logic [15:0] pc;
    logic [6:0]  sub;
  } frame_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } jump_s;
endpackage : flow_seq_pkg
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: subroutine calls, scheduled timer and step control over the register bus
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 8;
  logic                clk_sys = 1'b0;
  logic                reset   = 1'b1;
  logic                clkEn   = 1'b1;
  logic                hsel    = 1'b0;
  logic                hwrite  = 1'b0;
  logic                scanEnd = 1'b0;
  logic [31:0]         haddr   = 32'h0;
  logic [31:0]         hwdata  = 32'h0;
  logic [1:0]          htrans  = 2'b00;
  logic [15:0]         currentPc = 16'h0;
  logic [31:0]         extIrq  = 32'h0;
  logic                powerFail = 1'b0;
  logic                hreadyout;
  logic                hresp;
  logic [31:0]         hrdata;
  logic                instrErrorFlag;
  logic                stepStartFlag;
  logic                stepExec;
  logic [15:0]         stepClearMask;
  logic [15:0]         lastJump = 16'h0;
  logic [15:0]         clearSeen = 16'h0;
  logic [31:0]         rdat;
  logic [15:0]         pc0;
  flow_seq_pkg::jump_s jumpOut;
  int                  seed = 32'h47a338b0;
  int                  jumpCnt = 0;
  int                  mismatches = 0;
  int                  checked = 0;
  int                  n0;
  int                  i;

  program_flow_sequencer #(.TICK_CYCLES(TICKS), .NEST_DEPTH(16)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .currentPc(currentPc),
    .extIrq(extIrq), .scanEnd(scanEnd), .powerFail(powerFail), .jumpOut(jumpOut),
    .instrErrorFlag(instrErrorFlag), .stepStartFlag(stepStartFlag), .stepExec(stepExec),
    .stepClearMask(stepClearMask));

  always #12.5 clk_sys = ~clk_sys;

  // jump pulses last one cycle, so they are caught here rather than polled
  always @(posedge clk_sys) begin
    if (jumpOut.valid === 1'b1) begin
      jumpCnt++;
      lastJump = jumpOut.addr;
    end
    clearSeen = clearSeen | stepClearMask;
  end

  function automatic logic [7:0] bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction : bcd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // single word transfer; the address phase is held until hready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : xfer

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic call(input int n, input logic c);
    xfer(1'b1, flow_seq_pkg::ADDR_CALL, {23'h0, c, bcd(n)});
    settle();
  endtask : call

  task automatic clr_err();
    xfer(1'b1, flow_seq_pkg::ADDR_STATUS, 32'h1);
    settle();
  endtask : clr_err

  task automatic power_blip();
    powerFail <= 1'b1;
    @(posedge clk_sys);
    powerFail <= 1'b0;
  endtask : power_blip

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk(32'(stepStartFlag), 32'h0);
    xfer(1'b0, 8'h3c, 32'h0);
    chk(rdat, 32'h0);
    // subs 05 and 40..56 for nesting, 99 for the timer
    xfer(1'b1, flow_seq_pkg::ADDR_ENTRY, {bcd(5), 7'h0, 1'b1, 16'h0100});
    for (i = 40; i <= 56; i++)
      xfer(1'b1, flow_seq_pkg::ADDR_ENTRY, {bcd(i), 7'h0, 1'b1, 16'(i * 16)});
    xfer(1'b1, flow_seq_pkg::ADDR_ENTRY, {bcd(99), 7'h0, 1'b1, 16'h0500});
    n0 = jumpCnt;
    repeat (10 * TICKS) @(posedge clk_sys);
    chk(jumpCnt, n0);
    currentPc <= 16'($random(seed));
    call(5, 1'b0);
    chk(jumpCnt, n0);
    pc0 = currentPc;
    call(5, 1'b1);
    chk(lastJump, 16'h0100);
    n0 = jumpCnt;
    call(5, 1'b1);
    chk(32'(instrErrorFlag), 32'h1);
    chk(jumpCnt, n0);
    xfer(1'b1, flow_seq_pkg::ADDR_RETURN, 32'h0);
    settle();
    chk(lastJump, 16'(pc0 + 16'h1));
    n0 = jumpCnt;
    call(40, 1'b1);
    chk(jumpCnt, n0);
    clr_err();
    for (i = 0; i < 4; i++) begin
      call(60 + ($unsigned($random(seed)) % 39), 1'b1);
      chk(32'(instrErrorFlag), 32'h1);
      clr_err();
    end
    // nest sixteen deep, the seventeenth call is refused
    for (i = 40; i <= 56; i++) begin
      call(i, 1'b1);
      currentPc <= 16'($random(seed));
      if (i == 40)
        pc0 = currentPc;
    end
    chk(32'(instrErrorFlag), 32'h1);
    xfer(1'b0, flow_seq_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rdat[12:8]), 32'd16);
    clr_err();
    for (i = 0; i < 16; i++)
      xfer(1'b1, flow_seq_pkg::ADDR_RETURN, 32'h0);
    settle();
    chk(lastJump, 16'(pc0 + 16'h1));
    // bad designator and bad function code
    xfer(1'b1, flow_seq_pkg::ADDR_INT_DATA, 32'h2);
    xfer(1'b1, flow_seq_pkg::ADDR_INT_CMD, 32'h0005_0000);
    settle();
    chk(32'(instrErrorFlag), 32'h1);
    clr_err();
    xfer(1'b1, flow_seq_pkg::ADDR_INT_CMD, 32'h0004_0003);
    settle();
    chk(32'(instrErrorFlag), 32'h1);
    clr_err();
    xfer(1'b1, flow_seq_pkg::ADDR_INT_CMD, 32'h0004_0000);
    xfer(1'b1, flow_seq_pkg::ADDR_INT_DATA, 32'h3);
    xfer(1'b1, flow_seq_pkg::ADDR_INT_CMD, 32'h0004_0001);
    n0 = jumpCnt;
    for (i = 0; i < 200 && jumpCnt == n0; i++)
      @(posedge clk_sys);
    chk(lastJump, 16'h0500);
    chk(32'(i >= 2 * TICKS && i <= 4 * TICKS + 4), 32'h1);
    pc0 = currentPc;
    xfer(1'b1, flow_seq_pkg::ADDR_RETURN, 32'h0);
    settle();
    chk(lastJump, pc0);
    xfer(1'b1, flow_seq_pkg::ADDR_INT_CMD, 32'h0004_0002);
    xfer(1'b0, flow_seq_pkg::ADDR_INT_CMD, 32'h0);
    chk(32'(rdat[15:0]), 32'h2);
    xfer(1'b1, flow_seq_pkg::ADDR_INT_DATA, 32'h0);
    xfer(1'b1, flow_seq_pkg::ADDR_INT_CMD, 32'h0004_0000);
    xfer(1'b0, flow_seq_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rdat[2]), 32'h0);
    // leave subroutine 99 so that a surviving schedule would show as a jump
    xfer(1'b1, flow_seq_pkg::ADDR_RETURN, 32'h0);
    settle();
    n0 = jumpCnt;
    repeat (10 * TICKS) @(posedge clk_sys);
    chk(jumpCnt, n0);
    xfer(1'b1, flow_seq_pkg::ADDR_ENTRY, {bcd(3), 7'h0, 1'b1, 16'h0300});
    extIrq <= 32'h8;
    @(posedge clk_sys);
    extIrq <= 32'h0;
    settle();
    chk(lastJump, 16'h0300);
    xfer(1'b1, flow_seq_pkg::ADDR_SCAN_END, 32'h0);
    settle();
    chk(lastJump, flow_seq_pkg::PC_RESTART);
    // steps: bit 0 started, bit 1 never started
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_START, 32'h10);
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_DEF, 32'h10);
    settle();
    chk(32'(stepStartFlag), 32'h1);
    chk(32'(stepExec), 32'h1);
    @(posedge clk_sys);
    scanEnd <= 1'b1;
    @(posedge clk_sys);
    scanEnd <= 1'b0;
    settle();
    chk(32'(stepStartFlag), 32'h0);
    // starting bit 2 completes step 0; bit 1 stays unstarted
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_START, 32'h12);
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_DEF, 32'h11);
    settle();
    chk(32'(stepExec), 32'h0);
    chk(32'(clearSeen[0]), 32'h1);
    // dummy bit 15 started ahead of the closing define
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_START, 32'h1f);
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_DEF, 32'h0);
    xfer(1'b0, flow_seq_pkg::ADDR_STATUS, 32'h0);
    chk(32'(rdat[1]), 32'h0);
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_CTL, 32'h0001_0005);
    power_blip();
    xfer(1'b0, flow_seq_pkg::ADDR_STEP_CTL, 32'h0);
    chk(rdat, 32'h0001_0005);
    xfer(1'b1, flow_seq_pkg::ADDR_STEP_CTL, 32'h5);
    power_blip();
    xfer(1'b0, flow_seq_pkg::ADDR_STEP_CTL, 32'h0);
    chk(rdat, 32'h0);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
